// [cll_logic_top.sv]
`timescale 1ns/100ps
`default_nettype none

module cll_logic_top
  import cll_pkg::*;
(
  // clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  // avalon-mm slave
  input  wire logic [CLL_ADDR_W-1:0]   avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [CLL_DATA_W-1:0]   avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic      [CLL_DATA_W-1:0]   avs_readdata,
  output logic                         avs_waitrequest,
  // cell input sources
  input  wire logic [CLL_CELLS-1:0]    event_line_a,
  input  wire logic [CLL_CELLS-1:0]    event_line_b,
  input  wire logic [3*CLL_CELLS-1:0]  cell_pin_in,
  input  wire logic                    comparator_out,
  input  wire logic [1:0]              serial_tx,
  input  wire logic [1:0]              serial_host_mode,
  input  wire logic                    spi_data_out,
  input  wire logic                    spi_clock_out,
  input  wire logic                    spi_host_mode,
  input  wire logic [2:0]              timer16_waveform_output,
  input  wire logic [1:0]              timer_capture_waveform_output,
  // cell outputs
  output logic      [CLL_CELLS-1:0]    cell_output,
  output logic      [CLL_CELLS-1:0]    cell_output_enable
);

  // register file
  logic [CLL_REG_W-1:0] block_control;
  logic [CLL_REG_W-1:0] sequencer_control [CLL_PAIRS];
  logic [CLL_REG_W-1:0] cell_control_a    [CLL_CELLS];
  logic [CLL_REG_W-1:0] cell_control_b    [CLL_CELLS];
  logic [CLL_REG_W-1:0] cell_control_c    [CLL_CELLS];
  logic [CLL_REG_W-1:0] cell_truth_table  [CLL_CELLS];

  // datapath
  logic [CLL_CELLS-1:0] active;
  logic [CLL_CELLS-1:0] cell_locked;
  logic [CLL_CELLS-1:0] comb_result;
  logic [CLL_CELLS-1:0] raw_result;
  logic [CLL_CELLS-1:0] cell_result;
  logic [CLL_CELLS-1:0] cell_tick;
  logic [CLL_CELLS-1:0] pin_clocked;
  logic [CLL_CELLS-1:0] input2_level;
  logic [CLL_PAIRS-1:0] seq_state;
  logic [CLL_PAIRS-1:0] seq_used;
  logic [CLL_PAIRS-1:0] seq_view;

  // bus handshake
  logic                  wait_q;
  logic                  bus_req;
  logic                  wr_take;
  logic [5:0]            reg_index;
  logic [CLL_DATA_W-1:0] next_readdata;

  assign bus_req   = avs_read | avs_write;
  assign reg_index = avs_address[CLL_ADDR_W-1:2];
  assign wr_take   = avs_write & ~wait_q & avs_byteenable[0];

  // one wait cycle per access, then a single taken cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 1'b1;
    end else if (bus_req && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  assign avs_waitrequest = wait_q;

  // read mux; unmapped indices read zero
  always_comb begin
    next_readdata = RST_WORD;
    case (reg_index)
      IDX_BLOCK_CONTROL: next_readdata[CLL_REG_W-1:0] = block_control;
      IDX_SEQ_CONTROL_0: next_readdata[CLL_REG_W-1:0] = sequencer_control[0];
      IDX_SEQ_CONTROL_1: next_readdata[CLL_REG_W-1:0] = sequencer_control[1];
      IDX_CELL_STATUS:   next_readdata[CLL_REG_W-1:0] = {2'h0, seq_view, cell_output};
      default: begin
        for (int k = 0; k < CLL_CELLS; k++) begin
          if (reg_index == 6'(IDX_CELL_BASE + IDX_CELL_STRIDE * k + SUB_CONTROL_A)) begin
            next_readdata[CLL_REG_W-1:0] = cell_control_a[k];
          end
          if (reg_index == 6'(IDX_CELL_BASE + IDX_CELL_STRIDE * k + SUB_CONTROL_B)) begin
            next_readdata[CLL_REG_W-1:0] = cell_control_b[k];
          end
          if (reg_index == 6'(IDX_CELL_BASE + IDX_CELL_STRIDE * k + SUB_CONTROL_C)) begin
            next_readdata[CLL_REG_W-1:0] = cell_control_c[k];
          end
          if (reg_index == 6'(IDX_CELL_BASE + IDX_CELL_STRIDE * k + SUB_TRUTH)) begin
            next_readdata[CLL_REG_W-1:0] = cell_truth_table[k];
          end
        end
      end
    endcase
  end

  // read data loaded as waitrequest falls, so it stands at the taking edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= RST_WORD;
    end else if (avs_read && wait_q) begin
      avs_readdata <= next_readdata;
    end
  end

  // block control is never locked
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      block_control <= RST_REG;
    end else if (wr_take && reg_index == IDX_BLOCK_CONTROL) begin
      block_control <= avs_writedata[CLL_REG_W-1:0];
    end
  end

  // sequencer selection, locked by the even cell of the pair
  genvar p;
  generate
    for (p = 0; p < CLL_PAIRS; p++) begin : g_pair
      localparam logic [5:0] SEQ_IDX = 6'(IDX_SEQ_CONTROL_0 + p);
      logic [3:0] mode;
      logic       d_in;
      logic       g_in;

      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          sequencer_control[p] <= RST_REG;
        end else if (wr_take && reg_index == SEQ_IDX && !cell_control_a[2*p][CELL_ENABLE_BIT]) begin
          sequencer_control[p] <= avs_writedata[CLL_REG_W-1:0];
        end
      end

      assign mode        = sequencer_control[p][SEQ_SELECT_LSB +: 4];
      assign d_in        = cell_result[2*p];
      assign g_in        = cell_result[2*p+1];
      assign seq_used[p] = (mode != SEQ_OFF);
      // a disabled even cell hides the state at once, before the clearing edge
      assign seq_view[p] = seq_state[p] & active[2*p];

      // latches follow on every system clock; flip-flops on the even cell tick
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          seq_state[p] <= 1'b0;
        end else if (!active[2*p]) begin
          seq_state[p] <= 1'b0;
        end else begin
          case (mode)
            SEQ_D_FLIPFLOP_MODE: begin
              if (cell_tick[2*p] && g_in) begin
                seq_state[p] <= d_in;
              end
            end
            SEQ_JK_FLIPFLOP_MODE: begin
              if (cell_tick[2*p]) begin
                case ({d_in, g_in})
                  2'b01:   seq_state[p] <= 1'b0;
                  2'b10:   seq_state[p] <= 1'b1;
                  2'b11:   seq_state[p] <= ~seq_state[p];
                  default: seq_state[p] <= seq_state[p];
                endcase
              end
            end
            SEQ_D_LATCH_MODE: begin
              if (g_in) begin
                seq_state[p] <= d_in;
              end
            end
            SEQ_SET_RESET_LATCH_MODE: begin
              // forbidden set-and-reset simply holds
              if (d_in && !g_in) begin
                seq_state[p] <= 1'b1;
              end else if (g_in && !d_in) begin
                seq_state[p] <= 1'b0;
              end
            end
            default: seq_state[p] <= 1'b0;
          endcase
        end
      end
    end
  endgenerate

  // per-cell registers, input selection, table and filter
  genvar n;
  generate
    for (n = 0; n < CLL_CELLS; n++) begin : g_cell
      localparam logic [5:0] IDX_A = 6'(IDX_CELL_BASE + IDX_CELL_STRIDE * n + SUB_CONTROL_A);
      localparam logic [5:0] IDX_B = 6'(IDX_CELL_BASE + IDX_CELL_STRIDE * n + SUB_CONTROL_B);
      localparam logic [5:0] IDX_C = 6'(IDX_CELL_BASE + IDX_CELL_STRIDE * n + SUB_CONTROL_C);
      localparam logic [5:0] IDX_T = 6'(IDX_CELL_BASE + IDX_CELL_STRIDE * n + SUB_TRUTH);
      localparam int EVEN = n - (n % 2);
      localparam int NEXT = (n + 1) % CLL_CELLS;
      logic [2:0] sel_in;
      logic [3:0] sel_code [CLL_INPUTS];

      // locking follows the even cell of the pair
      assign cell_locked[n] = cell_control_a[EVEN][CELL_ENABLE_BIT];
      assign active[n]      = block_control[BLOCK_ENABLE_BIT] & cell_control_a[n][CELL_ENABLE_BIT];

      // enable bit always writable; other fields only while unlocked
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          cell_control_a[n] <= RST_REG;
        end else if (wr_take && reg_index == IDX_A) begin
          if (cell_locked[n]) begin
            cell_control_a[n][CELL_ENABLE_BIT] <= avs_writedata[CELL_ENABLE_BIT];
          end else begin
            cell_control_a[n] <= avs_writedata[CLL_REG_W-1:0];
          end
        end
      end

      // input selectors and truth table
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          cell_control_b[n]   <= RST_REG;
          cell_control_c[n]   <= RST_REG;
          cell_truth_table[n] <= RST_REG;
        end else if (wr_take && !cell_locked[n]) begin
          if (reg_index == IDX_B) begin
            cell_control_b[n] <= avs_writedata[CLL_REG_W-1:0];
          end
          if (reg_index == IDX_C) begin
            cell_control_c[n] <= avs_writedata[CLL_REG_W-1:0];
          end
          if (reg_index == IDX_T) begin
            cell_truth_table[n] <= avs_writedata[CLL_REG_W-1:0];
          end
        end
      end

      assign sel_code[0] = cell_control_b[n][INPUT_SELECT_0_LSB +: 4];
      assign sel_code[1] = cell_control_b[n][INPUT_SELECT_1_LSB +: 4];
      assign sel_code[2] = cell_control_c[n][INPUT_SELECT_2_LSB +: 4];

      // one source multiplexer per input position
      for (genvar y = 0; y < CLL_INPUTS; y++) begin : g_in
        always_comb begin
          case (sel_code[y])
            SRC_FEEDBACK: sel_in[y] = seq_view[n/2];
            SRC_LINK:     sel_in[y] = raw_result[NEXT];
            SRC_EVENT_A:  sel_in[y] = event_line_a[n];
            SRC_EVENT_B:  sel_in[y] = event_line_b[n];
            SRC_PIN:      sel_in[y] = cell_pin_in[3*n+y];
            SRC_COMPARE:  sel_in[y] = comparator_out;
            SRC_SERIAL:   sel_in[y] = (y < 2) ? (serial_tx[y%2] & serial_host_mode[y%2]) : 1'b0;
            SRC_SPI:      sel_in[y] = ((y < 2) ? spi_data_out : spi_clock_out) & spi_host_mode;
            SRC_TIMER16:  sel_in[y] = timer16_waveform_output[y];
            SRC_TIMERCAP: sel_in[y] = (y < 2) ? timer_capture_waveform_output[y%2] : 1'b0;
            default:      sel_in[y] = 1'b0;
          endcase
        end
      end

      // input 2 clocks the cell and is masked in the table when chosen
      assign pin_clocked[n]  = (cell_control_a[n][CLOCK_SOURCE_LSB +: 3] == CLOCK_SOURCE_PIN2);
      assign input2_level[n] = sel_in[2];
      assign comb_result[n]  = cell_truth_table[n][{sel_in[2] & ~pin_clocked[n], sel_in[1], sel_in[0]}];

      // registered unfiltered result; breaks loops through the link path
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          raw_result[n] <= 1'b0;
        end else begin
          raw_result[n] <= active[n] & comb_result[n];
        end
      end

      cll_cell_filter u_filter (
        .clk_sys            (clk_sys),
        .rst_n              (rst_n),
        .active             (active[n]),
        .clock_from_pin     (pin_clocked[n]),
        .filter_select      (cell_control_a[n][FILTER_SELECT_LSB +: 2]),
        .edge_detect_enable (cell_control_a[n][EDGE_DETECT_BIT]),
        .comb_in            (comb_result[n]),
        .clock_level        (input2_level[n]),
        .cell_out           (cell_result[n]),
        .cell_tick          (cell_tick[n])
      );

      // even output carries the sequencer when one is selected
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          cell_output[n]        <= 1'b0;
          cell_output_enable[n] <= 1'b0;
        end else begin
          if (!active[n]) begin
            cell_output[n] <= 1'b0;
          end else if ((n % 2 == 0) && seq_used[n/2]) begin
            cell_output[n] <= seq_view[n/2];
          end else begin
            cell_output[n] <= cell_result[n];
          end
          cell_output_enable[n] <= active[n] & cell_control_a[n][OUTPUT_ENABLE_BIT];
        end
      end
    end
  endgenerate

endmodule : cll_logic_top

`default_nettype wire

// [cll_pkg.sv]
package cll_pkg;

  // sizes of the block
  localparam int CLL_CELLS    = 4;
  localparam int CLL_PAIRS    = 2;
  localparam int CLL_INPUTS   = 3;
  localparam int CLL_ADDR_W   = 8;
  localparam int CLL_DATA_W   = 32;
  localparam int CLL_REG_W    = 8;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_BLOCK_CONTROL = 6'h00;
  localparam logic [5:0] IDX_SEQ_CONTROL_0 = 6'h01;
  localparam logic [5:0] IDX_SEQ_CONTROL_1 = 6'h02;
  localparam logic [5:0] IDX_CELL_BASE     = 6'h08;
  localparam logic [5:0] IDX_CELL_STRIDE   = 6'h04;
  localparam logic [5:0] IDX_CELL_STATUS   = 6'h20;

  // sub-offsets inside one cell group
  localparam logic [5:0] SUB_CONTROL_A = 6'h00;
  localparam logic [5:0] SUB_CONTROL_B = 6'h01;
  localparam logic [5:0] SUB_CONTROL_C = 6'h02;
  localparam logic [5:0] SUB_TRUTH     = 6'h03;

  // reset values
  localparam logic [7:0] RST_REG   = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // block_control fields
  localparam int BLOCK_ENABLE_BIT = 0;
  localparam int RUN_STANDBY_BIT  = 6;

  // cell_control_a fields
  localparam int CELL_ENABLE_BIT   = 0;
  localparam int CLOCK_SOURCE_LSB  = 1;
  localparam int FILTER_SELECT_LSB = 4;
  localparam int OUTPUT_ENABLE_BIT = 6;
  localparam int EDGE_DETECT_BIT   = 7;

  // cell_control_b / cell_control_c / sequencer_control fields
  localparam int INPUT_SELECT_0_LSB = 0;
  localparam int INPUT_SELECT_1_LSB = 4;
  localparam int INPUT_SELECT_2_LSB = 0;
  localparam int SEQ_SELECT_LSB     = 0;

  // cell_clock_source codes
  localparam logic [2:0] CLOCK_SOURCE_PER  = 3'h0;
  localparam logic [2:0] CLOCK_SOURCE_PIN2 = 3'h1;

  // filter_select codes
  localparam logic [1:0] FILTER_NONE = 2'h0;
  localparam logic [1:0] FILTER_SYNC = 2'h1;
  localparam logic [1:0] FILTER_GLITCH = 2'h2;

  // input source codes
  localparam logic [3:0] SRC_MASK     = 4'h0;
  localparam logic [3:0] SRC_FEEDBACK = 4'h1;
  localparam logic [3:0] SRC_LINK     = 4'h2;
  localparam logic [3:0] SRC_EVENT_A  = 4'h3;
  localparam logic [3:0] SRC_EVENT_B  = 4'h4;
  localparam logic [3:0] SRC_PIN      = 4'h5;
  localparam logic [3:0] SRC_COMPARE  = 4'h6;
  localparam logic [3:0] SRC_SERIAL   = 4'h8;
  localparam logic [3:0] SRC_SPI      = 4'h9;
  localparam logic [3:0] SRC_TIMER16  = 4'ha;
  localparam logic [3:0] SRC_TIMERCAP = 4'hc;

  // sequencer_select codes
  localparam logic [3:0] SEQ_OFF                  = 4'h0;
  localparam logic [3:0] SEQ_D_FLIPFLOP_MODE      = 4'h1;
  localparam logic [3:0] SEQ_JK_FLIPFLOP_MODE     = 4'h2;
  localparam logic [3:0] SEQ_D_LATCH_MODE         = 4'h3;
  localparam logic [3:0] SEQ_SET_RESET_LATCH_MODE = 4'h4;

endpackage : cll_pkg

// [cll_cell_filter.sv]
`timescale 1ns/100ps
`default_nettype none

module cll_cell_filter
  import cll_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // cell configuration
  input  wire logic       active,
  input  wire logic       clock_from_pin,
  input  wire logic [1:0] filter_select,
  input  wire logic       edge_detect_enable,
  // data
  input  wire logic       comb_in,
  input  wire logic       clock_level,
  output logic            cell_out,
  output logic            cell_tick
);

  logic       clock_prev;
  logic [2:0] stage;
  logic       held;
  logic       edge_prev;
  logic       pulse;
  logic       filtered;

  // cell clock: every system edge, or the rising edge of input 2
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clock_prev <= 1'b0;
    end else begin
      clock_prev <= clock_level;
    end
  end

  assign cell_tick = clock_from_pin ? (clock_level & ~clock_prev) : 1'b1;

  // sample chain and gated flip-flop; cleared the edge after disable
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stage <= 3'h0;
      held  <= 1'b0;
    end else if (!active) begin
      stage <= 3'h0;
      held  <= 1'b0;
    end else if (cell_tick) begin
      stage <= {stage[1:0], comb_in};
      // needs three equal samples, so the value lags four cell edges
      if (stage[0] == stage[1] && stage[1] == stage[2]) begin
        held <= stage[2];
      end
    end
  end

  // filter choice
  always_comb begin
    case (filter_select)
      FILTER_SYNC:   filtered = stage[1];
      FILTER_GLITCH: filtered = held;
      default:       filtered = comb_in;
    endcase
  end

  // rising edge detector, pulse stands one cell-clock period
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      edge_prev <= 1'b0;
      pulse     <= 1'b0;
    end else if (!active) begin
      edge_prev <= 1'b0;
      pulse     <= 1'b0;
    end else if (cell_tick) begin
      edge_prev <= filtered;
      pulse     <= filtered & ~edge_prev;
    end
  end

  assign cell_out = edge_detect_enable ? pulse : filtered;

endmodule : cll_cell_filter

`default_nettype wire

// [cll_src_model.sv]
`timescale 1ns/100ps
`default_nettype none
module cll_src_model (
  // clock and bench request
  input  wire logic        clk_sys,
  input  wire logic [11:0] pin_want,
  input  wire logic [2:0]  host_want,
  // source lines into the block
  output logic      [11:0] cell_pin_in,
  output logic      [3:0]  ev_a,
  output logic      [3:0]  ev_b,
  output logic      [9:0]  per_lines,
  output logic      [2:0]  host_mode
);
  logic [7:0] cnt = 8'h00;
  // pins follow the bench one edge later, like a synchronous driver
  always_ff @(posedge clk_sys) begin
    cell_pin_in <= pin_want;
    cnt <= cnt + 8'h01;
  end
  // events and peripherals keep moving so no line rests at a stale value
  assign ev_a = cnt[3:0];
  assign ev_b = ~cnt[3:0];
  assign per_lines = {cnt[5:0], cnt[7:4]};
  // host modes follow the bench so the masking of idle ports can be seen
  assign host_mode = host_want;
endmodule : cll_src_model
`default_nettype wire

// [cll_logic_chk.sv]
`timescale 1ns/100ps
`default_nettype none
module cll_logic_chk
  import cll_pkg::*;
(
  // watched ports
  input wire logic                  clk_sys,
  input wire logic                  rst_n,
  input wire logic [CLL_ADDR_W-1:0] avs_address,
  input wire logic                  avs_read,
  input wire logic                  avs_write,
  input wire logic [CLL_DATA_W-1:0] avs_writedata,
  input wire logic [3:0]            avs_byteenable,
  input wire logic [CLL_DATA_W-1:0] avs_readdata,
  input wire logic                  avs_waitrequest,
  input wire logic [CLL_CELLS-1:0]  cell_output,
  input wire logic [CLL_CELLS-1:0]  cell_output_enable
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [5:0] idx;
  logic       blk_en;
  logic [3:0] cell_en;
  assign idx = avs_address[7:2];
  // shadow enables; enable bits write even when the fields are locked
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      blk_en <= 1'b0;
      cell_en <= 4'h0;
    end else if (avs_write && !avs_waitrequest && avs_byteenable[0]) begin
      if (idx == IDX_BLOCK_CONTROL) blk_en <= avs_writedata[0];
      for (int n = 0; n < CLL_CELLS; n++)
        if (idx == IDX_CELL_BASE + 6'(4*n)) cell_en[n] <= avs_writedata[0];
    end
  end
  property p_wait_one;
    $fell(avs_waitrequest) |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait low over one cycle");
  property p_wait_idle;
    avs_waitrequest && !avs_read && !avs_write |=> avs_waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("wait dropped without request");
  property p_wait_cause;
    !avs_waitrequest |-> $past(avs_read || avs_write);
  endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
  property p_rd_upper;
    avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("read upper bits set");
  property p_rd_unmapped;
    avs_read && !avs_waitrequest && ((idx > 6'h02 && idx < 6'h08) || (idx > 6'h17 && idx != 6'h20))
      |-> avs_readdata == 32'h0;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
  property p_blk_off;
    !blk_en |=> (cell_output_enable == 4'h0);
  endproperty
  a_blk_off: assert property (p_blk_off) else $error("output enabled with block off");
  property p_cell_off;
    1'b1 |-> ((cell_output_enable & ~$past(cell_en)) == 4'h0);
  endproperty
  a_cell_off: assert property (p_cell_off) else $error("output enabled with cell off");
  property p_reset_out;
    $rose(rst_n) |-> cell_output == 4'h0 && avs_waitrequest;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs not cleared by reset");
endmodule : cll_logic_chk
bind cll_logic_top cll_logic_chk u_chk (.clk_sys, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_byteenable, .avs_readdata, .avs_waitrequest, .cell_output, .cell_output_enable);
`default_nettype wire

// [tb.sv]
`timescale 1ns/100ps
`default_nettype none
module tb
  import cll_pkg::*;
;
  logic        clk_sys, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [7:0]  avs_address, ca;
  logic [31:0] avs_writedata, avs_readdata, seed, exp_q[$], msk_q[$];
  logic [3:0]  avs_byteenable, ev_a, ev_b, cell_output, cell_output_enable, og;
  logic [11:0] pin_want, cell_pin_in;
  logic [9:0]  per_lines;
  logic [2:0]  host_mode, host_want;
  int          n_errors = 0;
  int          cmp_count = 0;
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  cll_src_model u_src (.clk_sys, .pin_want, .host_want, .cell_pin_in, .ev_a, .ev_b, .per_lines, .host_mode);
  cll_logic_top dut (.clk_sys, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .event_line_a(ev_a), .event_line_b(ev_b), .cell_pin_in,
    .comparator_out(per_lines[0]), .serial_tx(per_lines[2:1]), .serial_host_mode(host_mode[1:0]),
    .spi_data_out(per_lines[3]), .spi_clock_out(per_lines[4]), .spi_host_mode(host_mode[2]),
    .timer16_waveform_output(per_lines[7:5]), .timer_capture_waveform_output(per_lines[9:8]),
    .cell_output, .cell_output_enable);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic summarize();
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize
  task automatic check_rd(input logic [31:0] got);
    logic [31:0] e, m;
    e = exp_q.pop_front();
    m = msk_q.pop_front();
    cmp_count++;
    if ((got & m) !== e) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got & m, e);
    end
  endtask : check_rd
  // one avalon transfer; held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [5:0] ix, input logic [7:0] d);
    int k;
    avs_address <= {ix, 2'b00};
    avs_writedata <= {24'h0, d};
    avs_read <= !wr;
    avs_write <= wr;
    k = 0;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0 && k < 50) begin
      @(posedge clk_sys);
      k++;
    end
    if (k == 50) begin
      n_errors++;
      summarize();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys); // strobes drop for one edge before the next transfer
  endtask : bus
  task automatic wr(input logic [5:0] ix, input logic [7:0] d);
    bus(1'b1, ix, d);
  endtask : wr
  task automatic rd(input logic [5:0] ix, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(1'b0, ix, 8'h00);
  endtask : rd
  // reads are judged at the edge where the slave releases them
  always @(posedge clk_sys)
    if (rst_n && avs_read && avs_waitrequest === 1'b0) check_rd(avs_readdata);
  initial begin
    rst_n = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata, pin_want} = '0;
    avs_byteenable = 4'hf;
    host_want = 3'h7;
    seed = 32'h81b7;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    // cleared after reset, unmapped places hold nothing
    for (int i = 0; i < 6; i++) rd(6'(i < 3 ? i : i + 5), 32'h0, 32'hff);
    rd(6'h20, 32'h0, 32'hff);
    wr(6'h04, 8'h5a);
    rd(6'h04, 32'h0, 32'hff);
    wr(6'h00, 8'h01);
    // random tables walked under none, sync and glitch filter
    for (int f = 0; f < 3; f++) begin
      seed = lfsr(seed);
      ca = 8'h41 + 8'(f * 16);
      wr(6'h08, 8'h00);
      wr(6'h09, 8'h55);
      wr(6'h0a, 8'h05);
      wr(6'h0b, seed[7:0]);
      wr(6'h08, ca);
      rd(6'h08, {24'h0, ca}, 32'hff);
      for (int v = 0; v < 8; v++) begin
        pin_want <= 12'(v);
        repeat (10) @(posedge clk_sys);
        rd(6'h20, {31'h0, seed[v]}, 32'h1);
      end
      wr(6'h0b, ~seed[7:0]);
      rd(6'h0b, {24'h0, seed[7:0]}, 32'hff);
    end
    wr(6'h08, 8'h30);
    rd(6'h08, 32'h60, 32'hff);
    // masked inputs index entry zero whatever the pins show
    wr(6'h09, 8'h00);
    wr(6'h0a, 8'h00);
    wr(6'h08, 8'h41);
    pin_want <= 12'h007;
    repeat (10) @(posedge clk_sys);
    rd(6'h20, {31'h0, seed[0]}, 32'h1);
    // pair 0: cell 0 follows pin 0, cell 1 follows its pin 0
    wr(6'h08, 8'h00);
    wr(6'h09, 8'h05);
    wr(6'h0b, 8'haa);
    wr(6'h0d, 8'h05);
    wr(6'h0f, 8'haa);
    wr(6'h0c, 8'h01);
    // steps hold, set, clear, set; even input pattern equals the result
    for (int m = 1; m < 5; m++) begin
      wr(6'h08, 8'h00);
      wr(6'h01, 8'(m));
      og = (m % 2) ? 4'b1110 : 4'b0100;
      for (int i = 0; i < 4; i++) begin
        pin_want <= {8'h0, og[i], 2'b00, i[0]};
        if (i == 0) wr(6'h08, 8'h41);
        repeat (10) @(posedge clk_sys);
        rd(6'h20, {31'h0, i[0]}, 32'h1);
      end
    end
    // cell 3 reads cell 0 through the link, wrapping past the last cell
    wr(6'h15, 8'h02);
    wr(6'h17, 8'haa);
    wr(6'h14, 8'h01);
    for (int i = 0; i < 2; i++) begin
      pin_want <= 12'(i);
      repeat (10) @(posedge clk_sys);
      rd(6'h20, {28'h0, i[0], 3'h0}, 32'h8);
    end
    // serial and spi sources read low while their port is not host
    host_want <= 3'h0;
    wr(6'h11, 8'h98);
    wr(6'h13, 8'hee);
    wr(6'h10, 8'h01);
    for (int i = 0; i < 8; i++) begin
      repeat (30) @(posedge clk_sys);
      rd(6'h20, 32'h0, 32'h4);
    end
    wr(6'h00, 8'h00);
    repeat (4) @(posedge clk_sys);
    rd(6'h20, 32'h0, 32'hf);
    summarize();
  end
endmodule : tb
`default_nettype wire
